// ===== common/smsp_pkg.sv
// Package with register map, field positions and reset values of the port
package smsp_pkg;

  // Register byte offsets (word aligned)
  localparam logic [7:0] OFF_CORE_INT   = 8'h00;
  localparam logic [7:0] OFF_REQ_FLAGS  = 8'h04;
  localparam logic [7:0] OFF_ENABLES    = 8'h08;
  localparam logic [7:0] OFF_PRIORITY   = 8'h0c;
  localparam logic [7:0] OFF_RX_CTRL    = 8'h10;
  localparam logic [7:0] OFF_TX_BUF     = 8'h14;
  localparam logic [7:0] OFF_TX_CTRL    = 8'h18;
  localparam logic [7:0] OFF_BAUD       = 8'h1c;
  localparam logic [7:0] OFF_RX_BUF     = 8'h20;

  // Transmit status and control fields
  localparam int TXC_CLK_SRC   = 7;
  localparam int TXC_NINE      = 6;
  localparam int TXC_TX_EN     = 5;
  localparam int TXC_SYNC      = 4;
  localparam int TXC_HIGH_BAUD = 2;
  localparam int TXC_SHIFT_EMP = 1;
  localparam int TXC_NINTH     = 0;

  // Receive status and control fields
  localparam int RXC_PORT_EN   = 7;
  localparam int RXC_NINE      = 6;
  localparam int RXC_SINGLE    = 5;
  localparam int RXC_CONT      = 4;
  localparam int RXC_ADDR_DET  = 3;
  localparam int RXC_FRAME_ERR = 2;
  localparam int RXC_OVERRUN   = 1;
  localparam int RXC_NINTH     = 0;

  // Request, enable and priority fields
  localparam int FLG_RX = 5;
  localparam int FLG_TX = 4;

  // Core interrupt control fields
  localparam int CIC_GLOBAL = 7;
  localparam int CIC_PERIPH = 6;

  // Reset values
  localparam logic [7:0] RST_TX_CTRL = 8'h02;
  localparam logic [7:0] RST_ZERO    = 8'h00;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : smsp_pkg

// ===== sim/smsp_slave_model.sv
// Behavioural synchronous slave on the shift clock and data lines
`timescale 1ns/1ps
module smsp_slave_model (
  // Lines from the master
  input  wire logic       clk_line,
  input  wire logic       data_o,
  input  wire logic       data_oe,
  output logic            data_line,
  // Word to return
  input  wire logic       start,
  input  wire logic [8:0] word,
  input  wire logic [3:0] nbits,
  // Captured bits and clock period
  output logic [15:0]     cap,
  output int              cap_n,
  output int              period
);
  logic drv;
  int   idx;
  time  last;

  // Wire level: master when it drives, else the slave
  assign data_line = data_oe ? data_o : drv;

  // Idle state
  initial begin
    drv = 1'h0;
    idx = 0;
    last = 0;
    period = 0;
  end

  // New frame clears capture
  always @(posedge start) begin
    idx = 0;
    cap = 16'h0;
    cap_n = 0;
  end

  // Capture mid-bit, present next bit ahead of the master's fall
  always @(posedge clk_line) begin
    period = int'($time - last);
    last = $time;
    if (data_oe) begin
      cap = {data_o, cap[15:1]};
      cap_n++;
    end else if (start) begin
      drv = word[idx % nbits];
      idx++;
    end else begin
      drv = ~drv; // Toggles the line while not armed
    end
  end
endmodule : smsp_slave_model

// ===== sim/tb_smsp_top.sv
// Self-checking bench for the synchronous master serial port
`timescale 1ns/1ps
module tb_smsp_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, start;
  logic        ck_o, ck_oe, ck_line, dt_o, dt_oe, dt_line;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0]  wstrb, nbits;
  logic [1:0]  bresp, rresp, rrv;
  logic [8:0]  word, w0, w1;
  logic [15:0] cap;
  int          cap_n, period, fail_count, compares, seed;
  int          q[$];

  // Clock
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  assign ck_line = ck_oe ? ck_o : 1'h0;

  smsp_top #(.BAUD_W(8)) u_smsp_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .shift_clock_line_i(ck_line), .shift_clock_line_o(ck_o),
    .shift_clock_line_oe(ck_oe), .shift_data_line_i(dt_line),
    .shift_data_line_o(dt_o), .shift_data_line_oe(dt_oe), .irq(irq));

  smsp_slave_model u_smsp_slave_model (
    .clk_line(ck_line), .data_o(dt_o), .data_oe(dt_oe),
    .data_line(dt_line), .start(start), .word(word), .nbits(nbits),
    .cap(cap), .cap_n(cap_n), .period(period));

  // Verdict
  task automatic results;
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // Bound ran out
  task automatic hang;
    fail_count++;
    $display("wrong value at %0t: timeout", $time);
    results();
  endtask : hang

  // Register and response compare
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: reg %h exp %h", $time, g, e);
    end
  endtask : cmp_reg

  // Line and link compare
  task automatic cmp_line(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: line %h exp %h", $time, g, e);
    end
  endtask : cmp_line

  // AXI4-Lite write with response check
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] e = smsp_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'h1) awvalid <= 1'h0;
      if (wvalid && wready === 1'h1) wvalid <= 1'h0;
      if (n > 50) hang();
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    cmp_reg({30'h0, bresp}, {30'h0, e});
  endtask : wr

  // AXI4-Lite read
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'h1) arvalid <= 1'h0;
      if (n > 50) hang();
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    rdv = rdata;
    rrv = rresp;
  endtask : rd

  // Read, compare masked value and response
  task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    rd(a);
    cmp_reg(rdv & {24'hffffff, m}, {24'h0, e});
    cmp_reg({30'h0, rrv}, (a > smsp_pkg::OFF_RX_BUF) ?
            {30'h0, smsp_pkg::RESP_SLVERR} : {30'h0, smsp_pkg::RESP_OKAY});
  endtask : rdc

  // Poll a register field, bounded
  task automatic poll(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
      if (n > 400) hang();
    end while ((rdv[7:0] & m) !== e);
  endtask : poll

  // Restart the slave with a word
  task automatic arm(input logic [8:0] w, input logic [3:0] n);
    @(posedge aclk);
    start <= 1'h0;
    word  <= w;
    nbits <= n;
    @(posedge aclk);
    start <= 1'h1;
  endtask : arm

  // Wait for captured bits, bounded
  task automatic wait_bits(input int n);
    int k;
    k = 0;
    while (cap_n < n) begin
      @(posedge aclk);
      k++;
      if (k > 3000) hang();
    end
  endtask : wait_bits

  // Main sequence
  initial begin
    seed = 23529;
    fail_count = 0;
    compares = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, start} = 7'h0;
    {awaddr, araddr, wdata, word} = 57'h0;
    wstrb = 4'h1;
    nbits = 4'h8;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    // Reset values, reserved bits, unmapped place
    rdc(smsp_pkg::OFF_TX_CTRL, 8'hff, smsp_pkg::RST_TX_CTRL);
    rdc(smsp_pkg::OFF_REQ_FLAGS, 8'hff, 8'h10);
    cmp_line(ck_oe, 1'h0);
    wr(8'h24, 8'h5a, smsp_pkg::RESP_SLVERR);
    rdc(8'h24, 8'hff, 8'h00);
    wr(smsp_pkg::OFF_CORE_INT, 8'hc0);
    wr(smsp_pkg::OFF_PRIORITY, 8'hff);
    rdc(smsp_pkg::OFF_PRIORITY, 8'hff, 8'h30);
    wr(smsp_pkg::OFF_ENABLES, 8'hff);
    rdc(smsp_pkg::OFF_ENABLES, 8'hff, 8'h30);
    cmp_line(irq, 1'h1);
    wr(smsp_pkg::OFF_REQ_FLAGS, 8'h00);
    wr(smsp_pkg::OFF_ENABLES, 8'h20);
    rdc(smsp_pkg::OFF_REQ_FLAGS, 8'hff, 8'h10);
    cmp_line(irq, 1'h0);
    // Master set-up
    wr(smsp_pkg::OFF_BAUD, 8'h07);
    wr(smsp_pkg::OFF_RX_CTRL, 8'h80);
    wr(smsp_pkg::OFF_TX_CTRL, 8'hb0);
    rdc(smsp_pkg::OFF_TX_CTRL, 8'hff, 8'hb2);
    cmp_line(ck_oe, 1'h1);
    // Receive request while transmit enabled
    wr(smsp_pkg::OFF_RX_CTRL, 8'ha0);
    repeat (300) @(posedge aclk);
    rdc(smsp_pkg::OFF_REQ_FLAGS, 8'h20, 8'h00);
    cmp_line(period, 0);
    wr(smsp_pkg::OFF_RX_CTRL, 8'h80);
    // Back-to-back 8-bit words
    w0 = 9'($random(seed));
    w1 = 9'($random(seed));
    q = {int'(w0[7:0]), int'(w1[7:0])};
    arm(9'h0, 4'h8);
    wr(smsp_pkg::OFF_TX_BUF, w0[7:0]);
    rdc(smsp_pkg::OFF_REQ_FLAGS, 8'h10, 8'h10);
    rdc(smsp_pkg::OFF_TX_CTRL, 8'h02, 8'h00);
    wr(smsp_pkg::OFF_TX_BUF, w1[7:0]);
    rdc(smsp_pkg::OFF_REQ_FLAGS, 8'h10, 8'h00);
    wait_bits(16);
    poll(smsp_pkg::OFF_TX_CTRL, 8'h02, 8'h02);
    cmp_line(cap, 32'(q[0] | (q[1] << 8)));
    cmp_line(period, 160);
    // Nine-bit word
    wr(smsp_pkg::OFF_TX_CTRL, 8'hf1);
    arm(9'h0, 4'h9);
    wr(smsp_pkg::OFF_TX_BUF, w0[7:0]);
    wait_bits(9);
    poll(smsp_pkg::OFF_TX_CTRL, 8'h02, 8'h02);
    cmp_line(cap[15:7], {1'h1, w0[7:0]});
    // Single receive
    wr(smsp_pkg::OFF_TX_CTRL, 8'h90);
    arm(w1, 4'h8);
    wr(smsp_pkg::OFF_RX_CTRL, 8'ha0);
    poll(smsp_pkg::OFF_REQ_FLAGS, 8'h20, 8'h20);
    cmp_line(irq, 1'h1);
    rdc(smsp_pkg::OFF_RX_CTRL, 8'hff, 8'h80);
    rdc(smsp_pkg::OFF_RX_BUF, 8'hff, w1[7:0]);
    rdc(smsp_pkg::OFF_REQ_FLAGS, 8'h20, 8'h00);
    // Continuous nine-bit receive, both enables set
    w1 = 9'($random(seed));
    arm(w1, 4'h9);
    wr(smsp_pkg::OFF_RX_CTRL, 8'hf0);
    poll(smsp_pkg::OFF_REQ_FLAGS, 8'h20, 8'h20);
    rdc(smsp_pkg::OFF_RX_CTRL, 8'h01, {7'h0, w1[8]});
    rdc(smsp_pkg::OFF_RX_BUF, 8'hff, w1[7:0]);
    poll(smsp_pkg::OFF_REQ_FLAGS, 8'h20, 8'h20);
    rdc(smsp_pkg::OFF_RX_BUF, 8'hff, w1[7:0]);
    poll(smsp_pkg::OFF_RX_CTRL, 8'h02, 8'h02);
    wr(smsp_pkg::OFF_RX_CTRL, 8'h80);
    rdc(smsp_pkg::OFF_RX_CTRL, 8'h16, 8'h00);
    results();
  end
endmodule : tb_smsp_top

// ===== src/smsp_baud.sv
// Baud tick generator that paces each shift-clock half period
`timescale 1ns/1ps
module smsp_baud #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Control
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] divisor,
  // Tick out
  output logic                  tick
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;

  // Count down from divisor, tick on reaching zero
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = divisor;
    end else if (cnt_reg == '0) begin
      cnt_next  = divisor;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : smsp_baud

// ===== src/smsp_top.sv
// Synchronous master serial port with AXI4-Lite register access
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module smsp_top #(
  parameter int BAUD_W = 8
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Shift clock line pin
  input  wire logic        shift_clock_line_i,
  output logic             shift_clock_line_o,
  output logic             shift_clock_line_oe,
  // Shift data line pin
  input  wire logic        shift_data_line_i,
  output logic             shift_data_line_o,
  output logic             shift_data_line_oe,
  // Interrupt request
  output logic             irq
);

  typedef enum logic [1:0] {SMSP_IDLE, SMSP_TX, SMSP_RX} smsp_state_type;

  // Registers
  logic [7:0] cic_reg, cic_next, en_reg, en_next, pri_reg, pri_next;
  logic [7:0] rxc_reg, rxc_next, txc_reg, txc_next, baud_reg, baud_next;
  logic [8:0] txbuf_reg, txbuf_next, rxbuf_reg, rxbuf_next;
  logic       txfull_reg, txfull_next, rxflag_reg, rxflag_next;
  // Shifter state
  smsp_state_type st_reg, st_next;
  logic [8:0] sh_reg, sh_next;
  logic [3:0] bit_reg, bit_next;
  logic       ck_reg, ck_next, dout_reg, dout_next, doe_reg, doe_next;
  logic       ckoe_reg, ckoe_next, irq_reg, irq_next;
  // Bus state
  logic       aw_reg, aw_next, w_reg, w_next, b_reg, b_next;
  logic       ar_reg, ar_next, r_reg, r_next;
  logic [7:0] awa_reg, awa_next, ara_reg, ara_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic       din_s1_reg, din_s2_reg;
  logic       tick;
  logic       wr_do, rd_do, master_on, nine_tx, nine_rx, tx_word_end;

  // Data line synchroniser
  always_ff @(posedge aclk) begin
    din_s1_reg <= shift_data_line_i;
    din_s2_reg <= din_s1_reg;
  end

  // Master clock active only in synchronous master with port enabled
  assign master_on = txc_reg[smsp_pkg::TXC_CLK_SRC]
                   & txc_reg[smsp_pkg::TXC_SYNC]
                   & rxc_reg[smsp_pkg::RXC_PORT_EN];
  assign nine_tx = txc_reg[smsp_pkg::TXC_NINE];
  assign nine_rx = rxc_reg[smsp_pkg::RXC_NINE];
  assign wr_do = aw_reg & w_reg & ~b_reg;
  assign rd_do = ar_reg & ~r_reg;
  assign tx_word_end = (bit_reg == (nine_tx ? 4'd8 : 4'd7));

  // Baud pacing of each half period
  smsp_baud #(.WIDTH(BAUD_W)) u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (st_reg != SMSP_IDLE),
    .divisor (baud_reg),
    .tick    (tick)
  );

  // Read mux, only implemented bits
  function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                        input logic [7:0] t,
                                        input logic [7:0] r);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      smsp_pkg::OFF_CORE_INT:  v = cic_reg & 8'hc0;
      smsp_pkg::OFF_REQ_FLAGS: v = {2'b00, rxflag_reg, ~txfull_reg, 4'h0};
      smsp_pkg::OFF_ENABLES:   v = en_reg & 8'h30;
      smsp_pkg::OFF_PRIORITY:  v = pri_reg & 8'h30;
      smsp_pkg::OFF_RX_CTRL:   v = r;
      smsp_pkg::OFF_TX_BUF:    v = txbuf_reg[7:0];
      smsp_pkg::OFF_TX_CTRL:   v = t & 8'hf7;
      smsp_pkg::OFF_BAUD:      v = baud_reg;
      smsp_pkg::OFF_RX_BUF:    v = rxbuf_reg[7:0];
      default:                 v = 8'h00;
    endcase
    return v;
  endfunction : rd_mux

  // Decide whether an offset is mapped
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= smsp_pkg::OFF_RX_BUF);
  endfunction : mapped

  // Bus channel handling and register writes
  always_comb begin
    aw_next = aw_reg; w_next = w_reg; b_next = b_reg;
    ar_next = ar_reg; r_next = r_reg;
    awa_next = awa_reg; ara_next = ara_reg;
    wd_next = wd_reg; rd_next = rd_reg; br_next = br_reg; rr_next = rr_reg;
    cic_next = cic_reg; en_next = en_reg; pri_next = pri_reg;
    rxc_next = rxc_reg; txc_next = txc_reg; baud_next = baud_reg;
    txbuf_next = txbuf_reg; txfull_next = txfull_reg;
    if (s_axi_awvalid && !aw_reg) begin
      aw_next = 1'b1; awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_reg) begin
      w_next = 1'b1; wd_next = s_axi_wdata;
    end
    if (wr_do) begin
      aw_next = 1'b0; w_next = 1'b0; b_next = 1'b1;
      br_next = mapped(awa_reg) ? smsp_pkg::RESP_OKAY
                                : smsp_pkg::RESP_SLVERR;
      if (s_axi_wstrb[0]) begin
        unique case (awa_reg)
          smsp_pkg::OFF_CORE_INT: cic_next = wd_reg[7:0] & 8'hc0;
          smsp_pkg::OFF_ENABLES:  en_next  = wd_reg[7:0] & 8'h30;
          smsp_pkg::OFF_PRIORITY: pri_next = wd_reg[7:0] & 8'h30;
          smsp_pkg::OFF_RX_CTRL:  rxc_next[7:3] = wd_reg[7:3];
          smsp_pkg::OFF_TX_BUF: begin
            txbuf_next  = {txc_reg[smsp_pkg::TXC_NINTH], wd_reg[7:0]};
            txfull_next = 1'b1;
          end
          smsp_pkg::OFF_TX_CTRL: begin
            txc_next[7:4] = wd_reg[7:4];
            txc_next[smsp_pkg::TXC_HIGH_BAUD] = wd_reg[2];
            txc_next[smsp_pkg::TXC_NINTH] = wd_reg[0];
          end
          smsp_pkg::OFF_BAUD: baud_next = wd_reg[7:0];
          default: ;
        endcase
      end
    end
    if (b_reg && s_axi_bready) b_next = 1'b0;
    if (s_axi_arvalid && !ar_reg) begin
      ar_next = 1'b1; ara_next = s_axi_araddr;
    end
    if (rd_do) begin
      ar_next = 1'b0; r_next = 1'b1;
      rd_next = {24'h0, rd_mux(ara_reg, txc_reg, rxc_reg)};
      rr_next = mapped(ara_reg) ? smsp_pkg::RESP_OKAY
                                : smsp_pkg::RESP_SLVERR;
    end
    if (r_reg && s_axi_rready) r_next = 1'b0;
    // Clearing continuous enable releases the overrun error
    if (!rxc_next[smsp_pkg::RXC_CONT]) begin
      rxc_next[smsp_pkg::RXC_OVERRUN] = 1'b0;
    end
    rxc_next[smsp_pkg::RXC_FRAME_ERR] = 1'b0;
    // Status updates from the shifter, set wins over clear
    // A buffer write in the load cycle keeps the new word marked full
    if (st_reg == SMSP_IDLE && txfull_reg && master_on
        && txc_reg[smsp_pkg::TXC_TX_EN]
        && !(wr_do && s_axi_wstrb[0]
             && awa_reg == smsp_pkg::OFF_TX_BUF)) begin
      txfull_next = 1'b0;
    end
    if (st_reg == SMSP_RX && tick && ck_reg
        && bit_reg == (nine_rx ? 4'd8 : 4'd7)) begin
      rxc_next[smsp_pkg::RXC_NINTH] = nine_rx ? din_s2_reg : 1'b0;
      if (rxflag_reg && rxc_reg[smsp_pkg::RXC_CONT]) begin
        rxc_next[smsp_pkg::RXC_OVERRUN] = 1'b1;
      end
      if (rxc_reg[smsp_pkg::RXC_SINGLE]
          && !rxc_reg[smsp_pkg::RXC_CONT]) begin
        rxc_next[smsp_pkg::RXC_SINGLE] = 1'b0;
      end
    end
    txc_next[smsp_pkg::TXC_SHIFT_EMP] = (st_next != SMSP_TX);
    txc_next[3] = 1'b0;
  end

  // Shifter: transmit, receive and shift clock generation
  always_comb begin
    st_next = st_reg; sh_next = sh_reg; bit_next = bit_reg;
    ck_next = ck_reg; dout_next = dout_reg; doe_next = doe_reg;
    rxbuf_next = rxbuf_reg; rxflag_next = rxflag_reg;
    ckoe_next = master_on;
    if (rd_do && ara_reg == smsp_pkg::OFF_RX_BUF) rxflag_next = 1'b0;
    unique case (st_reg)
      SMSP_IDLE: begin
        ck_next = 1'b0;
        bit_next = 4'd0;
        doe_next = 1'b0;
        if (master_on && txfull_reg && txc_reg[smsp_pkg::TXC_TX_EN]) begin
          st_next = SMSP_TX;
          sh_next = txbuf_reg;
          dout_next = txbuf_reg[0];
          doe_next = 1'b1;
        end else if (master_on && !txc_reg[smsp_pkg::TXC_TX_EN]
                     && (rxc_reg[smsp_pkg::RXC_SINGLE]
                         || rxc_reg[smsp_pkg::RXC_CONT])) begin
          st_next = SMSP_RX;
        end
      end
      SMSP_TX: begin
        if (!master_on) begin
          st_next = SMSP_IDLE;
        end else if (tick) begin
          ck_next = ~ck_reg;
          if (ck_reg) begin
            if (tx_word_end) begin
              st_next = SMSP_IDLE;
            end else begin
              sh_next = {1'b0, sh_reg[8:1]};
              dout_next = sh_reg[1];
              bit_next = bit_reg + 4'd1;
            end
          end
        end
      end
      SMSP_RX: begin
        if (!master_on || !(rxc_reg[smsp_pkg::RXC_SINGLE]
                            || rxc_reg[smsp_pkg::RXC_CONT])) begin
          st_next = SMSP_IDLE;
        end else if (tick) begin
          ck_next = ~ck_reg;
          if (ck_reg) begin
            // Falling edge: sample data
            sh_next = nine_rx ? {din_s2_reg, sh_reg[8:1]}
                              : {1'b0, din_s2_reg, sh_reg[7:1]};
            bit_next = bit_reg + 4'd1;
            if (bit_reg == (nine_rx ? 4'd8 : 4'd7)) begin
              rxbuf_next = nine_rx ? {din_s2_reg, sh_reg[8:1]}
                                   : {1'b0, din_s2_reg, sh_reg[7:1]};
              rxflag_next = 1'b1;
              bit_next = 4'd0;
              if (!rxc_reg[smsp_pkg::RXC_CONT]) st_next = SMSP_IDLE;
            end
          end
        end
      end
      default: st_next = SMSP_IDLE;
    endcase
    // Flags raised regardless of enables, enables gate the request
    irq_next = ((rxflag_reg & en_reg[smsp_pkg::FLG_RX])
               | (~txfull_reg & en_reg[smsp_pkg::FLG_TX]))
               & cic_reg[smsp_pkg::CIC_GLOBAL]
               & cic_reg[smsp_pkg::CIC_PERIPH];
  end

  // Register all state except the data line synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cic_reg <= smsp_pkg::RST_ZERO; en_reg <= smsp_pkg::RST_ZERO;
      pri_reg <= smsp_pkg::RST_ZERO; rxc_reg <= smsp_pkg::RST_ZERO;
      txc_reg <= smsp_pkg::RST_TX_CTRL; baud_reg <= smsp_pkg::RST_ZERO;
      txbuf_reg <= '0; rxbuf_reg <= '0; txfull_reg <= 1'b0;
      rxflag_reg <= 1'b0; st_reg <= SMSP_IDLE; sh_reg <= '0;
      bit_reg <= '0; ck_reg <= 1'b0; dout_reg <= 1'b0; doe_reg <= 1'b0;
      ckoe_reg <= 1'b0; irq_reg <= 1'b0;
      aw_reg <= 1'b0; w_reg <= 1'b0; b_reg <= 1'b0; ar_reg <= 1'b0;
      r_reg <= 1'b0; awa_reg <= '0; ara_reg <= '0; wd_reg <= '0;
      rd_reg <= '0; br_reg <= '0; rr_reg <= '0;
    end else begin
      cic_reg <= cic_next; en_reg <= en_next; pri_reg <= pri_next;
      rxc_reg <= rxc_next; txc_reg <= txc_next; baud_reg <= baud_next;
      txbuf_reg <= txbuf_next; rxbuf_reg <= rxbuf_next;
      txfull_reg <= txfull_next; rxflag_reg <= rxflag_next;
      st_reg <= st_next; sh_reg <= sh_next; bit_reg <= bit_next;
      ck_reg <= ck_next; dout_reg <= dout_next; doe_reg <= doe_next;
      ckoe_reg <= ckoe_next; irq_reg <= irq_next;
      aw_reg <= aw_next; w_reg <= w_next; b_reg <= b_next;
      ar_reg <= ar_next; r_reg <= r_next; awa_reg <= awa_next;
      ara_reg <= ara_next; wd_reg <= wd_next; rd_reg <= rd_next;
      br_reg <= br_next; rr_reg <= rr_next;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = ~aw_reg;
  assign s_axi_wready = ~w_reg;
  assign s_axi_bvalid = b_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = ~ar_reg;
  assign s_axi_rvalid = r_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
  assign shift_clock_line_o = ck_reg;
  assign shift_clock_line_oe = ckoe_reg;
  assign shift_data_line_o = dout_reg;
  assign shift_data_line_oe = doe_reg;
  assign irq = irq_reg;

  // Checks on the shifter
  property p_half_duplex;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == SMSP_RX) |-> !doe_reg;
  endproperty
  a_half_duplex: assert property (p_half_duplex)
    else $error("data driven while receiving");

  property p_shift_empty;
    @(posedge aclk) disable iff (!aresetn)
      ##1 txc_reg[smsp_pkg::TXC_SHIFT_EMP] == (st_reg != SMSP_TX);
  endproperty
  a_shift_empty: assert property (p_shift_empty)
    else $error("shift empty status wrong");

  property p_load_clears_full;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == SMSP_IDLE && $past(st_reg) == SMSP_IDLE && st_next == SMSP_TX
       && !wr_do) |=> !txfull_reg && st_reg == SMSP_TX;
  endproperty
  a_load_clears_full: assert property (p_load_clears_full)
    else $error("buffer not emptied on load");

  property p_no_clock_off;
    @(posedge aclk) disable iff (!aresetn)
      !master_on |=> !ckoe_reg;
  endproperty
  a_no_clock_off: assert property (p_no_clock_off)
    else $error("clock driven outside master mode");

  property p_rx_flag;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == SMSP_RX && tick && ck_reg && bit_reg == 4'd7 && !nine_rx
       && master_on) |=> rxflag_reg;
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("receive flag not set");

  property p_err_clear;
    @(posedge aclk) disable iff (!aresetn)
      !rxc_reg[smsp_pkg::RXC_CONT] |-> !rxc_reg[smsp_pkg::RXC_OVERRUN];
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error held without continuous enable");

  property p_tx_no_rx;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == SMSP_TX) |=> (st_reg != SMSP_RX);
  endproperty
  a_tx_no_rx: assert property (p_tx_no_rx)
    else $error("receive started from transmit");

  property p_ck_idle_low;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == SMSP_IDLE) |=> !ck_reg;
  endproperty
  a_ck_idle_low: assert property (p_ck_idle_low)
    else $error("shift clock high while idle");

endmodule : smsp_top
